//--- io_port_consts.svh
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH
// Byte offsets
`define OFF_DATA_A 8'h00
`define OFF_DIR_A 8'h10
`define OFF_IRQ_CTRL 8'h20
`define OFF_TMODE 8'h24
`define OFF_CONV_CTRL 8'h28
`define OFF_WAKE_EN 8'h2c
`define OFF_PULL_CFG 8'h30
`define OFF_ALT_CFG 8'h34
`define OFF_PWR_CTRL 8'h38
`define OFF_BITOP 8'h3c
`define OFF_IRQ_STAT 8'h40
`define OFF_IRQ_MASK 8'h44
`define OFF_STEP 4
// Reset values
`define RST_PIN_BIT 1'b1
`define RST_TMODE 2'h2
// Timer mode codes
`define TM_INTERNAL 2'h2
// Shared pins
`define PIN_PWM0 0
`define PIN_PWM1 1
`define PIN_PFD 3
`define PIN_TMR 4
`define PIN_INT 5
// Port indices
`define PORT_A 0
`define PORT_B 1
`define PORT_C 2
`define PORT_D 3
// Fields
`define ALT_PFD 0
`define ALT_PWM0 1
`define ALT_PWM1 2
`define ALT_W 3
`define CONV_W 4
`define TMODE_W 2
`define BITOP_PORT_LSB 3
`define BITOP_VAL 5
`define BITOP_DIR 6
`define PWR_DOWN_BIT 0
`define EV_WAKE 0
`define EV_EXT 1
`define EV_W 2
`endif

//--- io_port_pkg.sv
`include "io_port_consts.svh"
package io_port_pkg;
  typedef logic [31:0] wb_word_t;
  typedef logic [7:0] wb_addr_t;
  typedef logic [1:0] port_idx_t;
  typedef enum logic {PWR_RUN, PWR_DOWN} pwr_state_t;
endpackage : io_port_pkg

//--- io_sync.sv
`timescale 1ns/1ps
`include "io_port_consts.svh"
module io_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Three stages; level moves only when stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {W{`RST_PIN_BIT}};
      s2_q <= {W{`RST_PIN_BIT}};
      s3_q <= {W{`RST_PIN_BIT}};
      level_o <= {W{`RST_PIN_BIT}};
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_o <= (s2_q & s3_q) | (level_o & (s2_q ^ s3_q));
    end
  end
endmodule : io_sync

//--- io_port.sv
`timescale 1ns/1ps
`include "io_port_consts.svh"
module io_port #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wr_data_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic wr_dir_i,
  input wire logic [W-1:0] wdir_i,
  input wire logic [W-1:0] pin_lvl_i,
  input wire logic [W-1:0] force_in_i,
  input wire logic [W-1:0] alt_en_i,
  input wire logic [W-1:0] alt_val_i,
  input wire logic [W-1:0] pull_en_i,
  output logic [W-1:0] data_o,
  output logic [W-1:0] dir_o,
  output logic [W-1:0] rd_o,
  output logic [W-1:0] pad_out_o,
  output logic [W-1:0] pad_oe_o,
  output logic [W-1:0] pad_pull_o
);
  logic [W-1:0] in_mask;
  logic [W-1:0] alt_on;

  assign in_mask = dir_o | force_in_i;
  assign alt_on = alt_en_i & ~dir_o; // R12 R13
  assign rd_o = (in_mask & pin_lvl_i) | (~in_mask & data_o); // R1 R3 R5

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_o <= {W{`RST_PIN_BIT}}; // R6
    end else if (wr_data_i) begin
      data_o <= wdata_i; // R4
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_o <= {W{`RST_PIN_BIT}}; // R6
    end else if (wr_dir_i) begin
      dir_o <= wdir_i;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_o <= {W{`RST_PIN_BIT}};
      pad_oe_o <= '0;
      pad_pull_o <= '0;
    end else begin
      pad_out_o <= (alt_on & alt_val_i) | (~alt_on & data_o); // R2
      pad_oe_o <= ~in_mask; // R1 R2
      pad_pull_o <= in_mask & pull_en_i; // R9
    end
  end
endmodule : io_port

//--- bidir_io_port_block.sv
// Functional notes
// R1: Direction one makes pin a readable input
// R2: Direction zero drives pin from output latch
// R3: Reading an output pin returns latch
// R4: Output latch holds until rewritten
// R5: Input pins sampled at read, never latched
// R6: Reset sets all data and direction ones
// R7: Port A falling edge wakes power-down
// R8: Bit set/clear is read-modify-write
// R9: Pull-high only while pin is input
// R10: External interrupt enable takes interrupt pin
// R11: Non-internal timer mode takes timer pin
// R12: Divider output only when direction output
// R13: Pulse-width outputs only when direction output
// R14: Analog-selected pins lose pull-high
// R15: Unbonded pins keep full register behaviour
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "io_port_consts.svh"
module bidir_io_port_block #(
  parameter int PORT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire io_port_pkg::wb_addr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire io_port_pkg::wb_word_t wb_dat_i,
  output io_port_pkg::wb_word_t wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4*PORT_W-1:0] pin_in,
  output logic [4*PORT_W-1:0] pin_out,
  output logic [4*PORT_W-1:0] pin_oe,
  output logic [4*PORT_W-1:0] pin_pull,
  input wire logic pfd_i,
  input wire logic pwm0_i,
  input wire logic pwm1_i,
  output logic timer_event_pin,
  output logic power_down_o,
  output logic wake_o,
  output logic irq_o
);
  import io_port_pkg::*;

  localparam int NP = 4;
  localparam int BIT_W = $clog2(PORT_W);

  logic [NP-1:0][PORT_W-1:0] sync_lvl;
  logic [NP-1:0][PORT_W-1:0] rd_val;
  logic [NP-1:0][PORT_W-1:0] data_q_v;
  logic [NP-1:0][PORT_W-1:0] dir_q_v;
  logic [NP-1:0][PORT_W-1:0] wdat_d;
  logic [NP-1:0][PORT_W-1:0] wdir_d;
  logic [NP-1:0][PORT_W-1:0] force_in;
  logic [NP-1:0][PORT_W-1:0] alt_en;
  logic [NP-1:0][PORT_W-1:0] alt_val;
  logic [NP-1:0][PORT_W-1:0] pull_en;
  logic [NP-1:0] wr_data;
  logic [NP-1:0] wr_dir;

  logic irq_ctrl_q;
  logic [`TMODE_W-1:0] tmode_q;
  logic [`CONV_W-1:0] conv_sel_q;
  logic [PORT_W-1:0] wake_en_q;
  logic [NP-1:0] pull_cfg_q;
  logic [`ALT_W-1:0] alt_cfg_q;
  logic [`EV_W-1:0] irq_stat_q;
  logic [`EV_W-1:0] irq_mask_q;
  logic [`EV_W-1:0] ev;
  logic [`EV_W-1:0] stat_clr;
  logic [`EV_W-1:0] irq_stat_d;
  logic [`EV_W-1:0] irq_mask_d;
  logic [PORT_W-1:0] prev_a_q;
  logic [PORT_W-1:0] fall_a;
  pwr_state_t pwr_q;
  pwr_state_t pwr_d;
  logic wake_d;

  logic req;
  logic wr;
  wb_addr_t a;
  wb_word_t rdata;
  logic bop;
  port_idx_t bop_port;
  logic [BIT_W-1:0] bop_bit;
  logic bop_val;
  logic bop_dir;

  // Bus request decode
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign a = {wb_adr_i[7:2], 2'b00};
  assign bop = wr && (a == `OFF_BITOP);
  assign bop_bit = wb_dat_i[BIT_W-1:0];
  assign bop_port = wb_dat_i[`BITOP_PORT_LSB +: 2];
  assign bop_val = wb_dat_i[`BITOP_VAL];
  assign bop_dir = wb_dat_i[`BITOP_DIR];

  // Write steering, byte writes and bit operations
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      wr_data[p] = wr && (a == 8'(`OFF_DATA_A + `OFF_STEP * p));
      wr_dir[p] = wr && (a == 8'(`OFF_DIR_A + `OFF_STEP * p));
      wdat_d[p] = wb_dat_i[PORT_W-1:0];
      wdir_d[p] = wb_dat_i[PORT_W-1:0];
      if (bop && (bop_port == 2'(p))) begin
        if (bop_dir) begin
          wr_dir[p] = 1'b1;
          wdir_d[p] = dir_q_v[p];
          wdir_d[p][bop_bit] = bop_val;
        end else begin
          wr_data[p] = 1'b1;
          wdat_d[p] = rd_val[p]; // R8
          wdat_d[p][bop_bit] = bop_val; // R8
        end
      end
    end
  end

  // Pin sharing and pull-high selection
  always_comb begin
    force_in = '0;
    alt_en = '0;
    alt_val = '0;
    for (int p = 0; p < NP; p++) begin
      pull_en[p] = {PORT_W{pull_cfg_q[p]}};
    end
    force_in[`PORT_A][`PIN_INT] = irq_ctrl_q; // R10
    force_in[`PORT_A][`PIN_TMR] = (tmode_q != `TM_INTERNAL); // R11
    alt_en[`PORT_A][`PIN_PFD] = alt_cfg_q[`ALT_PFD]; // R12
    alt_val[`PORT_A][`PIN_PFD] = pfd_i;
    alt_en[`PORT_D][`PIN_PWM0] = alt_cfg_q[`ALT_PWM0]; // R13
    alt_en[`PORT_D][`PIN_PWM1] = alt_cfg_q[`ALT_PWM1]; // R13
    alt_val[`PORT_D][`PIN_PWM0] = pwm0_i;
    alt_val[`PORT_D][`PIN_PWM1] = pwm1_i;
    pull_en[`PORT_B][`CONV_W-1:0] = pull_en[`PORT_B][`CONV_W-1:0] & ~conv_sel_q; // R14
  end

  // Every pin slot exists whether bonded or not
  for (genvar g = 0; g < NP; g++) begin : g_port
    io_sync #(.W(PORT_W)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_i(pin_in[g*PORT_W +: PORT_W]),
      .level_o(sync_lvl[g])
    );
    io_port #(.W(PORT_W)) u_port ( // R15
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_data_i(wr_data[g]),
      .wdata_i(wdat_d[g]),
      .wr_dir_i(wr_dir[g]),
      .wdir_i(wdir_d[g]),
      .pin_lvl_i(sync_lvl[g]),
      .force_in_i(force_in[g]),
      .alt_en_i(alt_en[g]),
      .alt_val_i(alt_val[g]),
      .pull_en_i(pull_en[g]),
      .data_o(data_q_v[g]),
      .dir_o(dir_q_v[g]),
      .rd_o(rd_val[g]),
      .pad_out_o(pin_out[g*PORT_W +: PORT_W]),
      .pad_oe_o(pin_oe[g*PORT_W +: PORT_W]),
      .pad_pull_o(pin_pull[g*PORT_W +: PORT_W])
    );
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ctrl_q <= 1'b0;
      tmode_q <= `RST_TMODE;
      conv_sel_q <= '0;
      wake_en_q <= '0;
      pull_cfg_q <= '0;
      alt_cfg_q <= '0;
      irq_mask_q <= '0;
    end else if (wr) begin
      if (a == `OFF_IRQ_CTRL) begin
        irq_ctrl_q <= wb_dat_i[0];
      end
      if (a == `OFF_TMODE) begin
        tmode_q <= wb_dat_i[`TMODE_W-1:0];
      end
      if (a == `OFF_CONV_CTRL) begin
        conv_sel_q <= wb_dat_i[`CONV_W-1:0];
      end
      if (a == `OFF_WAKE_EN) begin
        wake_en_q <= wb_dat_i[PORT_W-1:0];
      end
      if (a == `OFF_PULL_CFG) begin
        pull_cfg_q <= wb_dat_i[NP-1:0];
      end
      if (a == `OFF_ALT_CFG) begin
        alt_cfg_q <= wb_dat_i[`ALT_W-1:0];
      end
      if (a == `OFF_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[`EV_W-1:0];
      end
    end
  end

  // Port A edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_a_q <= {PORT_W{`RST_PIN_BIT}};
    end else begin
      prev_a_q <= sync_lvl[`PORT_A];
    end
  end

  assign fall_a = prev_a_q & ~sync_lvl[`PORT_A];

  // Power-down and wake-up
  always_comb begin
    pwr_d = pwr_q;
    wake_d = 1'b0;
    unique case (pwr_q)
      PWR_RUN: begin
        if (wr && (a == `OFF_PWR_CTRL) && wb_dat_i[`PWR_DOWN_BIT]) begin
          pwr_d = PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (|(fall_a & wake_en_q)) begin
          pwr_d = PWR_RUN; // R7
          wake_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_RUN;
      power_down_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      power_down_o <= (pwr_d == PWR_DOWN);
      wake_o <= wake_d;
    end
  end

  // Sticky events, write one to clear, set wins
  always_comb begin
    ev = '0;
    ev[`EV_WAKE] = wake_d;
    ev[`EV_EXT] = irq_ctrl_q & fall_a[`PIN_INT];
    stat_clr = (wr && (a == `OFF_IRQ_STAT)) ? wb_dat_i[`EV_W-1:0] : '0;
    irq_stat_d = (irq_stat_q & ~stat_clr) | ev;
    // Next mask too, so a mask write shows on the output at once
    irq_mask_d = (wr && (a == `OFF_IRQ_MASK)) ? wb_dat_i[`EV_W-1:0] : irq_mask_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_o <= |(irq_stat_d & irq_mask_d);
    end
  end

  // Timer input pin level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_event_pin <= `RST_PIN_BIT;
    end else begin
      timer_event_pin <= sync_lvl[`PORT_A][`PIN_TMR];
    end
  end

  // Read data
  always_comb begin
    rdata = '0;
    case (a)
      `OFF_IRQ_CTRL: rdata[0] = irq_ctrl_q;
      `OFF_TMODE: rdata[`TMODE_W-1:0] = tmode_q;
      `OFF_CONV_CTRL: rdata[`CONV_W-1:0] = conv_sel_q;
      `OFF_WAKE_EN: rdata[PORT_W-1:0] = wake_en_q;
      `OFF_PULL_CFG: rdata[NP-1:0] = pull_cfg_q;
      `OFF_ALT_CFG: rdata[`ALT_W-1:0] = alt_cfg_q;
      `OFF_PWR_CTRL: rdata[`PWR_DOWN_BIT] = (pwr_q == PWR_DOWN);
      `OFF_IRQ_STAT: rdata[`EV_W-1:0] = irq_stat_q;
      `OFF_IRQ_MASK: rdata[`EV_W-1:0] = irq_mask_q;
      default: rdata = '0;
    endcase
    for (int p = 0; p < NP; p++) begin
      if (a == 8'(`OFF_DATA_A + `OFF_STEP * p)) begin
        rdata[PORT_W-1:0] = rd_val[p]; // R3 R5
      end
      if (a == 8'(`OFF_DIR_A + `OFF_STEP * p)) begin
        rdata[PORT_W-1:0] = dir_q_v[p];
      end
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // Checks
  logic seen_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_input_no_drive: assert property ( // R1
    ##1 (pin_oe[PORT_W-1:0] & $past(dir_q_v[`PORT_A])) == '0
  ) else $error("input pin driven");

  a_output_drives: assert property ( // R2
    ##1 pin_oe[2*PORT_W +: PORT_W] == ~$past(dir_q_v[`PORT_C])
  ) else $error("output enable does not follow direction");

  a_read_latch: assert property ( // R3
    (req && !wb_we_i && a == 8'(`OFF_DATA_A + `OFF_STEP * `PORT_C) && dir_q_v[`PORT_C] == '0)
    |=> wb_ack_o && wb_dat_o[PORT_W-1:0] == $past(data_q_v[`PORT_C])
  ) else $error("output read did not return latch");

  a_latch_hold: assert property ( // R4
    !wr_data[`PORT_C] |=> $stable(data_q_v[`PORT_C])
  ) else $error("latch changed without write");

  a_input_sample: assert property ( // R5
    (req && !wb_we_i && a == 8'(`OFF_DATA_A + `OFF_STEP * `PORT_C) && dir_q_v[`PORT_C] == '1)
    |=> wb_dat_o[PORT_W-1:0] == $past(sync_lvl[`PORT_C])
  ) else $error("input read not sampled at read");

  a_reset_ones: assert property ( // R6
    !seen_q |-> data_q_v == '1 && dir_q_v == '1
  ) else $error("reset value not all ones");

  a_wake_exit: assert property ( // R7
    (pwr_q == PWR_DOWN && |(fall_a & wake_en_q)) |=> pwr_q == PWR_RUN && wake_o ##1 !wake_o
  ) else $error("wake-up missed");

  a_bitop_rmw: assert property ( // R8
    (bop && !bop_dir && bop_port == 2'(`PORT_B))
    |=> data_q_v[`PORT_B][$past(bop_bit)] == $past(bop_val)
  ) else $error("bit operation lost");

  a_pull_input_only: assert property ( // R9
    (pin_pull & pin_oe) == '0
  ) else $error("pull-high on output");

  a_ext_int_input: assert property ( // R10
    irq_ctrl_q |=> !pin_oe[`PIN_INT]
  ) else $error("interrupt pin driven");

  a_timer_pin_input: assert property ( // R11
    (tmode_q != `TM_INTERNAL) |=> !pin_oe[`PIN_TMR]
  ) else $error("timer pin driven");

  a_pfd_gate: assert property ( // R12
    (alt_cfg_q[`ALT_PFD] && !dir_q_v[`PORT_A][`PIN_PFD]) |=> pin_out[`PIN_PFD] == $past(pfd_i)
  ) else $error("divider output not on pin");

  a_pwm_gate: assert property ( // R13
    (alt_cfg_q[`ALT_PWM0] && !dir_q_v[`PORT_D][`PIN_PWM0])
    |=> pin_out[3*PORT_W + `PIN_PWM0] == $past(pwm0_i)
  ) else $error("pulse-width output not on pin");

  a_analog_nopull: assert property ( // R14
    conv_sel_q[0] |=> !pin_pull[PORT_W]
  ) else $error("pull-high on analog pin");

  a_irq_level: assert property (
    irq_o == (|(irq_stat_q & irq_mask_q))
  ) else $error("interrupt output low with pending event");

endmodule : bidir_io_port_block

//--- pin_partner.sv
`timescale 1ns/1ps
module pin_partner #(
  parameter int N = 32
) (
  input wire logic sys_clk,
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  input wire logic [N-1:0] pin_pull,
  input wire logic [N-1:0] ext_drive,
  input wire logic [N-1:0] ext_lvl,
  output logic [N-1:0] pin_in
);
  logic [N-1:0] float_q = '0;

  // Undriven, unpulled pins wander every cycle
  always @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  // Device drive wins, then switch, then pull-high, else floating
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_lvl)
    | (~pin_oe & ~ext_drive & pin_pull) | (~pin_oe & ~ext_drive & ~pin_pull & float_q);
endmodule : pin_partner

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import io_port_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_sel = 4'hf;
  wb_addr_t wb_adr = 8'h00;
  wb_word_t wb_wdat = '0;
  wb_word_t wb_rdat, rd;
  logic wb_ack, timer_event_pin, power_down, wake, irq;
  logic [31:0] pin_in, pin_out, pin_oe, pin_pull;
  logic [31:0] ext_lvl = '1;
  logic [31:0] ext_drive = '1;
  logic freq_divider_out = 1'b0, pwm0 = 1'b0, pwm1 = 1'b0;
  int bad_count = 0, check_count = 0, cycles = 0;
  int unsigned seed_dummy, v;
  logic [7:0] data_m [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] dir_m [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
  logic [3:0] pull_m = 4'h0, conv_m = 4'h0;
  logic [2:0] alt_m = 3'h0;
  logic irqc_m = 1'b0;
  logic [1:0] tmode_m = 2'h2;

  bidir_io_port_block #(.PORT_W(8)) bidir_io_port_block_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull(pin_pull), .pfd_i(freq_divider_out), .pwm0_i(pwm0), .pwm1_i(pwm1),
    .timer_event_pin(timer_event_pin), .power_down_o(power_down), .wake_o(wake), .irq_o(irq));
  pin_partner #(.N(32)) pin_partner_inst (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull(pin_pull), .ext_drive(ext_drive), .ext_lvl(ext_lvl), .pin_in(pin_in));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      $display("[ERR] %0t run limit reached", $time);
      end_of_test();
    end
  end

  task automatic chk32(input wb_word_t got, input wb_word_t exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb_xfer(input wb_addr_t a, input logic w, input wb_word_t d, input logic [3:0] s,
                         output wb_word_t q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= s;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    chk1(wb_ack, 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wb_xfer

  task automatic wr(input wb_addr_t a, input wb_word_t d);
    wb_xfer(a, 1'b1, d, 4'hf, rd);
  endtask : wr

  task automatic rdchk(input wb_addr_t a, input wb_word_t exp);
    wb_xfer(a, 1'b0, '0, 4'hf, rd);
    chk32(rd, exp);
  endtask : rdchk

  task automatic check_pins(input logic do_read);
    wb_word_t d, o, p;
    repeat (5) @(posedge sys_clk);
    #1;
    d = {dir_m[3], dir_m[2], dir_m[1], dir_m[0]};
    if (irqc_m) d[5] = 1'b1;
    if (tmode_m != 2'h2) d[4] = 1'b1;
    o = {data_m[3], data_m[2], data_m[1], data_m[0]};
    if (alt_m[0]) o[3] = freq_divider_out;
    if (alt_m[1]) o[24] = pwm0;
    if (alt_m[2]) o[25] = pwm1;
    for (int i = 0; i < 4; i++) p[i*8 +: 8] = pull_m[i] ? d[i*8 +: 8] : 8'h00;
    p[11:8] = p[11:8] & ~conv_m;
    chk32(pin_oe, ~d);
    chk32(pin_out & ~d, o & ~d);
    chk32(pin_pull, p);
    chk1(timer_event_pin, d[4] ? ext_lvl[4] : o[4]);
    @(posedge sys_clk);
    for (int i = 0; i < 4 && do_read; i++) begin
      rdchk(8'(i * 4), {24'h0, (dir_m[i] & ext_lvl[i*8 +: 8]) | (~dir_m[i] & data_m[i])});
    end
  endtask : check_pins

  initial begin
    seed_dummy = $urandom(888);
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check_pins(1'b1);
    for (int i = 0; i < 4; i++) rdchk(8'(8'h10 + i * 4), 32'hff);
    for (int i = 0; i < 10; i++) rdchk(8'(8'h20 + i * 4), (i == 1) ? 32'h2 : 32'h0);
    wr(8'h80, 32'hff);
    rdchk(8'h80, 32'h0);
    for (int it = 0; it < 60; it++) begin
      v = $urandom;
      case (v[9:8])
        2'd0: begin
          wb_xfer(8'(v[11:10] * 4), 1'b1, 32'(v[7:0]), {3'h7, v[12]}, rd);
          if (v[12]) data_m[v[11:10]] = v[7:0];
        end
        2'd1: begin
          wr(8'(8'h10 + v[11:10] * 4), 32'(v[7:0]));
          dir_m[v[11:10]] = v[7:0];
        end
        2'd2: begin
          if (v[6]) begin
            dir_m[v[4:3]][v[2:0]] = v[5];
          end else begin
            data_m[v[4:3]] = (dir_m[v[4:3]] & ext_lvl[v[4:3]*8 +: 8]) | (~dir_m[v[4:3]] & data_m[v[4:3]]);
            data_m[v[4:3]][v[2:0]] = v[5];
          end
          wr(8'h3c, 32'(v[6:0]));
        end
        default: begin
          wr(8'h30, 32'(v[3:0]));
          wr(8'h28, 32'(v[7:4]));
          wr(8'h34, 32'(v[14:12]));
          pull_m = v[3:0];
          conv_m = v[7:4];
          alt_m = v[14:12];
        end
      endcase
      ext_lvl <= $urandom;
      freq_divider_out <= v[20];
      pwm0 <= v[21];
      pwm1 <= v[22];
      check_pins(1'b1);
    end
    wr(8'h10, 32'h00);
    dir_m[0] = 8'h00;
    wr(8'h20, 32'h1);
    irqc_m = 1'b1;
    check_pins(1'b0);
    wr(8'h20, 32'h0);
    irqc_m = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h24, 32'((i + 3) % 4));
      tmode_m = 2'((i + 3) % 4);
      check_pins(1'b0);
    end
    wr(8'h10, 32'hff);
    dir_m[0] = 8'hff;
    ext_lvl <= '1;
    repeat (6) @(posedge sys_clk);
    wr(8'h40, 32'h3);
    wr(8'h44, 32'h1);
    wr(8'h2c, 32'h04);
    wr(8'h38, 32'h1);
    chk1(power_down, 1'b1);
    ext_lvl[1] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk1(power_down, 1'b1);
    ext_lvl[2] <= 1'b0;
    for (int n = 0; n < 20 && wake !== 1'b1; n++) @(posedge sys_clk);
    chk1(wake, 1'b1);
    chk1(power_down, 1'b0);
    rdchk(8'h40, 32'h1);
    chk1(irq, 1'b1);
    wr(8'h44, 32'h0);
    chk1(irq, 1'b0);
    wr(8'h44, 32'h1);
    chk1(irq, 1'b1);
    wr(8'h40, 32'h1);
    chk1(irq, 1'b0);
    rdchk(8'h40, 32'h0);
    wr(8'h20, 32'h1);
    ext_lvl <= '1;
    repeat (6) @(posedge sys_clk);
    ext_lvl <= 32'hffff_ffdb;
    repeat (8) @(posedge sys_clk);
    rdchk(8'h40, 32'h2);
    chk1(irq, 1'b0);
    wr(8'h44, 32'h3);
    chk1(irq, 1'b1);
    end_of_test();
  end
endmodule : tb_top
